/* File: logic/mfc_ctrl.sv */
// mac port fifo control: ready thresholds, underflow policy and overflow pass handling
//
// What this block does
// - stop-on-underflow set: underflow flushes the whole tx fifo and halts transmit.
// - while halted on underflow, flow-control packets may still be sent.
// - underflow halt raises packet-event interrupt if enabled, never a port-stop interrupt.
// - stop-on-underflow clear: drop only the affected packet, then send the next.
// - tx ready only when tx free space >= 16 x (tx threshold + 1) bytes.
// - rx ready only when rx fill >= 16 x (rx threshold + 1) bytes.
// - overflow with pass bit: forward packet normally, still report the event.
// - overflow without pass: discard packet; signal rx fail if already started.
`timescale 1ns/1ps
`include "mfc_map.svh"
module mfc_ctrl #(
    parameter int DEPTH = `MFC_FIFO_DEPTH,
    parameter int BYTES_PER_WORD = `MFC_BYTES_PER_WORD
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reg_cs,
    input wire logic reg_we,
    input wire logic [`MFC_ADDR_W-1:0] reg_addr,
    input wire logic [`MFC_REG_W-1:0] reg_wdata,
    output logic [`MFC_REG_W-1:0] reg_rdata,
    input wire logic pkt_event_int_en,
    output logic packet_event_interrupt,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire mfc_pkg::mfc_tx_word_s tx_in_word,
    output logic tx_ready,
    output logic mac_tx_valid,
    input wire logic mac_tx_ready,
    output mfc_pkg::mfc_tx_word_s mac_tx_word,
    input wire logic mac_tx_underflow,
    input wire logic tx_restart,
    output logic tx_halted,
    input wire logic fc_req,
    output logic fc_grant,
    input wire logic mac_rx_valid,
    output logic mac_rx_ready,
    input wire mfc_pkg::mfc_rx_word_s mac_rx_word,
    output logic rx_ready,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output mfc_pkg::mfc_rx_word_s rx_out_word,
    output logic rx_fail,
    output logic rx_event_seen,
    output logic rx_event_passed
);
    import mfc_pkg::*;

    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int TXW = $bits(mfc_tx_word_s);
    localparam int RXW = $bits(mfc_rx_word_s);

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    logic [`MFC_REG_W-1:0] err_act_r;
    logic [`MFC_REG_W-1:0] err_act_nxt;
    logic [`MFC_REG_W-1:0] thr_r;
    logic [`MFC_REG_W-1:0] thr_nxt;
    logic [`MFC_REG_W-1:0] rdata_r;
    logic [`MFC_REG_W-1:0] rdata_nxt;
    logic halt_on_tx_underflow;
    logic pass_overflowed_packets;
    logic [`MFC_TTH_W-1:0] tx_free_space_threshold;
    logic [`MFC_RTH_W-1:0] rx_fill_threshold;

    // reserved and out-of-scope bits are masked off and read back as zero
    always_comb begin
        err_act_nxt = err_act_r;
        thr_nxt = thr_r;
        rdata_nxt = rdata_r;
        if (reg_cs && reg_we) begin
            if (reg_addr == `MFC_ERR_ACT_OFS) begin
                err_act_nxt = reg_wdata & `MFC_ERR_ACT_MASK;
            end
            if (reg_addr == `MFC_THR_OFS) begin
                thr_nxt = reg_wdata & `MFC_THR_MASK;
            end
        end else if (reg_cs) begin
            unique case (reg_addr)
                `MFC_ERR_ACT_OFS: rdata_nxt = err_act_r;
                `MFC_THR_OFS: rdata_nxt = thr_r;
                default: rdata_nxt = `MFC_RD_NONE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            err_act_r <= `MFC_ERR_ACT_RST;
            thr_r <= `MFC_THR_RST;
            rdata_r <= `MFC_RD_NONE;
        end else begin
            err_act_r <= err_act_nxt;
            thr_r <= thr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign halt_on_tx_underflow = err_act_r[`MFC_HALT_UNF_BIT];
    assign pass_overflowed_packets = err_act_r[`MFC_PASS_OVF_BIT];
    assign tx_free_space_threshold = thr_r[`MFC_TTH_MSB:`MFC_TTH_LSB];
    assign rx_fill_threshold = thr_r[`MFC_RTH_MSB:`MFC_RTH_LSB];

    // ----------------------------------------------------------------
    // transmit fifo and underflow policy
    // ----------------------------------------------------------------
    mfc_tx_state_e tx_st_r;
    mfc_tx_state_e tx_st_nxt;
    logic irq_r;
    logic irq_nxt;
    logic tx_flush;
    logic txf_in_valid;
    logic txf_in_ready;
    logic txf_out_valid;
    logic txf_out_ready;
    logic [TXW-1:0] txf_out_data;
    logic [CNT_W-1:0] txf_count;
    logic [`MFC_LVL_W-1:0] tx_free_bytes;
    logic tx_free_ok;
    mfc_tx_word_s txf_word;

    assign txf_word = mfc_tx_word_s'(txf_out_data);

    // underflow is acted on only in MFC_TX_RUN, even with the fifo empty; a second one while dropping or halted is moot
    always_comb begin
        tx_st_nxt = tx_st_r;
        irq_nxt = 1'b0;
        tx_flush = 1'b0;
        mac_tx_valid = 1'b0;
        txf_out_ready = 1'b0;
        txf_in_valid = tx_in_valid;
        unique case (tx_st_r)
            MFC_TX_RUN: begin
                mac_tx_valid = txf_out_valid;
                txf_out_ready = mac_tx_ready;
                if (mac_tx_underflow && halt_on_tx_underflow) begin
                    tx_st_nxt = MFC_TX_HALT;
                    tx_flush = 1'b1;
                    mac_tx_valid = 1'b0;
                    txf_out_ready = 1'b0;
                    txf_in_valid = 1'b0;
                    irq_nxt = pkt_event_int_en;
                end else if (mac_tx_underflow) begin
                    tx_st_nxt = MFC_TX_DROP;
                    mac_tx_valid = 1'b0;
                    txf_out_ready = 1'b0;
                end
            end
            MFC_TX_DROP: begin
                // rest of the broken packet is thrown away up to and including its last word
                txf_out_ready = 1'b1;
                if (txf_out_valid && txf_word.eop) begin
                    tx_st_nxt = MFC_TX_RUN;
                end
            end
            MFC_TX_HALT: begin
                // fifo is held empty so nothing queued can leak out before software restarts
                tx_flush = 1'b1;
                txf_in_valid = 1'b0;
                if (tx_restart) begin
                    tx_st_nxt = MFC_TX_RUN;
                end
            end
            default: begin
                tx_st_nxt = MFC_TX_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_st_r <= MFC_TX_RUN;
            irq_r <= 1'b0;
        end else begin
            tx_st_r <= tx_st_nxt;
            irq_r <= irq_nxt;
        end
    end

    mfc_fifo #(
        .WIDTH(TXW),
        .DEPTH(DEPTH)
    ) u_tx_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .flush(tx_flush),
        .in_valid(txf_in_valid),
        .in_ready(txf_in_ready),
        .in_data(tx_in_word),
        .out_valid(txf_out_valid),
        .out_ready(txf_out_ready),
        .out_data(txf_out_data),
        .count(txf_count)
    );

    // free space in bytes; ready is recomputed every cycle from the live count
    assign tx_free_bytes = `MFC_LVL_W'((DEPTH - int'(txf_count)) * BYTES_PER_WORD);

    mfc_level_cmp #(
        .FIELD_W(`MFC_TTH_W),
        .LVL_W(`MFC_LVL_W)
    ) u_tx_cmp (
        .level_bytes(tx_free_bytes),
        .field(tx_free_space_threshold),
        .at_or_above(tx_free_ok)
    );

    assign tx_ready = tx_free_ok && (tx_st_r != MFC_TX_HALT);
    assign tx_in_ready = txf_in_ready && (tx_st_r != MFC_TX_HALT);
    assign mac_tx_word = txf_word;
    assign tx_halted = (tx_st_r == MFC_TX_HALT);
    assign packet_event_interrupt = irq_r;
    // pause frames come from the mac itself, not the fifo, so the halt does not gate them
    assign fc_grant = fc_req;

    // ----------------------------------------------------------------
    // receive fifo and overflow pass policy
    // ----------------------------------------------------------------
    mfc_rx_state_e rx_st_r;
    mfc_rx_state_e rx_st_nxt;
    logic fail_r;
    logic fail_nxt;
    logic seen_r;
    logic seen_nxt;
    logic passed_r;
    logic passed_nxt;
    logic rxf_out_valid;
    logic rxf_out_ready;
    logic [RXW-1:0] rxf_out_data;
    logic [CNT_W-1:0] rxf_count;
    logic [`MFC_LVL_W-1:0] rx_fill_bytes;
    logic rx_fill_ok;
    logic rx_bad;
    mfc_rx_word_s rxf_word;

    assign rxf_word = mfc_rx_word_s'(rxf_out_data);
    assign rx_bad = rxf_word.ovf && !pass_overflowed_packets;

    // a dropped packet is reported once, on the word where the drop starts
    always_comb begin
        rx_st_nxt = rx_st_r;
        fail_nxt = 1'b0;
        seen_nxt = 1'b0;
        passed_nxt = 1'b0;
        rx_out_valid = 1'b0;
        rxf_out_ready = 1'b0;
        unique case (rx_st_r)
            MFC_RX_IDLE, MFC_RX_MID: begin
                if (rxf_out_valid && rx_bad) begin
                    rxf_out_ready = 1'b1;
                    seen_nxt = 1'b1;
                    fail_nxt = (rx_st_r == MFC_RX_MID);
                    rx_st_nxt = rxf_word.eop ? MFC_RX_IDLE : MFC_RX_DROP;
                end else begin
                    rx_out_valid = rxf_out_valid;
                    rxf_out_ready = rx_out_ready;
                    if (rxf_out_valid && rx_out_ready) begin
                        rx_st_nxt = rxf_word.eop ? MFC_RX_IDLE : MFC_RX_MID;
                        // passed overflow packets are still reported, on their last word
                        seen_nxt = rxf_word.ovf && rxf_word.eop;
                        passed_nxt = rxf_word.ovf && rxf_word.eop;
                    end
                end
            end
            MFC_RX_DROP: begin
                rxf_out_ready = 1'b1;
                if (rxf_out_valid && rxf_word.eop) begin
                    rx_st_nxt = MFC_RX_IDLE;
                end
            end
            default: begin
                rx_st_nxt = MFC_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_st_r <= MFC_RX_IDLE;
            fail_r <= 1'b0;
            seen_r <= 1'b0;
            passed_r <= 1'b0;
        end else begin
            rx_st_r <= rx_st_nxt;
            fail_r <= fail_nxt;
            seen_r <= seen_nxt;
            passed_r <= passed_nxt;
        end
    end

    mfc_fifo #(
        .WIDTH(RXW),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .flush(1'b0),
        .in_valid(mac_rx_valid),
        .in_ready(mac_rx_ready),
        .in_data(mac_rx_word),
        .out_valid(rxf_out_valid),
        .out_ready(rxf_out_ready),
        .out_data(rxf_out_data),
        .count(rxf_count)
    );

    // stored data in bytes; only rx_ready follows the threshold, rx_out_valid shows a short packet at once
    assign rx_fill_bytes = `MFC_LVL_W'(int'(rxf_count) * BYTES_PER_WORD);

    mfc_level_cmp #(
        .FIELD_W(`MFC_RTH_W),
        .LVL_W(`MFC_LVL_W)
    ) u_rx_cmp (
        .level_bytes(rx_fill_bytes),
        .field(rx_fill_threshold),
        .at_or_above(rx_fill_ok)
    );

    assign rx_ready = rx_fill_ok;
    assign rx_out_word = rxf_word;
    assign rx_fail = fail_r;
    assign rx_event_seen = seen_r;
    assign rx_event_passed = passed_r;
endmodule : mfc_ctrl

/* File: logic/mfc_map.svh */
// register offsets, field positions, reset values and scaling constants for the mac fifo control block
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH

// ----------------------------------------------------------------
// register port
// ----------------------------------------------------------------
`define MFC_ADDR_W 8
`define MFC_REG_W 16
`define MFC_ERR_ACT_OFS 8'h20
`define MFC_THR_OFS 8'h22
`define MFC_ERR_ACT_RST 16'h0000
`define MFC_THR_RST 16'h0303
`define MFC_ERR_ACT_MASK 16'h0101
`define MFC_THR_MASK 16'h3f7f
`define MFC_RD_NONE 16'h0000

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define MFC_HALT_UNF_BIT 0
`define MFC_PASS_OVF_BIT 8
`define MFC_TTH_MSB 13
`define MFC_TTH_LSB 8
`define MFC_RTH_MSB 6
`define MFC_RTH_LSB 0
`define MFC_TTH_W 6
`define MFC_RTH_W 7

// ----------------------------------------------------------------
// data path and threshold scaling
// ----------------------------------------------------------------
`define MFC_DATA_W 64
`define MFC_BYTES_PER_WORD 8
`define MFC_FIFO_DEPTH 8
`define MFC_LVL_W 16
`define MFC_THR_UNIT_SHIFT 4

`endif

/* File: logic/mfc_pkg.sv */
// types shared by the mac fifo control block
`include "mfc_map.svh"

package mfc_pkg;

    // word on the transmit path, host toward mac
    typedef struct packed {
        logic eop;
        logic [`MFC_DATA_W-1:0] data;
    } mfc_tx_word_s;

    // word on the receive path; ovf marks a packet hit by receive fifo overflow
    typedef struct packed {
        logic ovf;
        logic eop;
        logic [`MFC_DATA_W-1:0] data;
    } mfc_rx_word_s;

    typedef enum logic [2:0] {
        MFC_TX_RUN = 3'b001,
        MFC_TX_DROP = 3'b010,
        MFC_TX_HALT = 3'b100
    } mfc_tx_state_e;

    typedef enum logic [2:0] {
        MFC_RX_IDLE = 3'b001,
        MFC_RX_MID = 3'b010,
        MFC_RX_DROP = 3'b100
    } mfc_rx_state_e;

endpackage : mfc_pkg

/* File: logic/mfc_fifo.sv */
// synchronous fifo with valid/ready on both sides, a flush input and an occupancy count
`timescale 1ns/1ps
module mfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int CNT_W = $clog2(DEPTH + 1),
    parameter int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CNT_W-1:0] count
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] wr_ptr_nxt;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W-1:0] rd_ptr_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // handshake
    // ----------------------------------------------------------------
    // full and empty come straight from the count, so they never lie
    assign in_ready = (cnt_r != CNT_W'(DEPTH)) && !flush;
    assign out_valid = (cnt_r != '0) && !flush;
    assign out_data = mem_r[rd_ptr_r];
    assign count = cnt_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count next values; flush empties in one cycle
    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt = cnt_r;
        if (flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (push) begin
                wr_ptr_nxt = (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr_r + 1'b1);
            end
            if (pop) begin
                rd_ptr_nxt = (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr_r + 1'b1);
            end
            cnt_nxt = CNT_W'(cnt_r + CNT_W'(push) - CNT_W'(pop));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage needs no reset; the count guards every read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
endmodule : mfc_fifo

/* File: logic/mfc_level_cmp.sv */
// compares a byte level against a threshold of 16 x (field + 1) bytes
`timescale 1ns/1ps
`include "mfc_map.svh"
module mfc_level_cmp #(
    parameter int FIELD_W = 6,
    parameter int LVL_W = 16
) (
    input wire logic [LVL_W-1:0] level_bytes,
    input wire logic [FIELD_W-1:0] field,
    output logic at_or_above
);
    logic [LVL_W-1:0] thr_bytes;

    // purely combinational, so a new field value counts from the next compare
    assign thr_bytes = LVL_W'(({{(LVL_W-FIELD_W){1'b0}}, field} + 1'b1) << `MFC_THR_UNIT_SHIFT);
    assign at_or_above = (level_bytes >= thr_bytes);
endmodule : mfc_level_cmp

/* File: tb/mfc_ctrl_monitor.sv */
// checker for the mac fifo control block, bound to its top module
`timescale 1ns/1ps
`include "mfc_map.svh"
module mfc_ctrl_monitor
    import mfc_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int BYTES_PER_WORD = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reg_cs,
    input wire logic reg_we,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic pkt_event_int_en,
    input wire logic packet_event_interrupt,
    input wire logic tx_in_ready,
    input wire logic tx_ready,
    input wire logic mac_tx_valid,
    input wire logic mac_tx_underflow,
    input wire logic tx_restart,
    input wire logic tx_halted,
    input wire logic fc_req,
    input wire logic fc_grant,
    input wire logic rx_out_valid,
    input wire mfc_pkg::mfc_rx_word_s rx_out_word,
    input wire logic rx_fail,
    input wire logic rx_event_seen,
    input wire logic rx_event_passed
);
    logic [15:0] err_r, err_nxt, thr_r, thr_nxt, rd_exp;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // shadow registers, masked on write so reserved bits read back as zero
    always_comb begin
        err_nxt = err_r;
        thr_nxt = thr_r;
        if (reg_cs && reg_we && reg_addr == `MFC_ERR_ACT_OFS) err_nxt = reg_wdata & `MFC_ERR_ACT_MASK;
        if (reg_cs && reg_we && reg_addr == `MFC_THR_OFS) thr_nxt = reg_wdata & `MFC_THR_MASK;
        rd_exp = (reg_addr == `MFC_ERR_ACT_OFS) ? err_r : (reg_addr == `MFC_THR_OFS) ? thr_r : 16'h0000;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            err_r <= `MFC_ERR_ACT_RST;
            thr_r <= `MFC_THR_RST;
        end else begin
            err_r <= err_nxt;
            thr_r <= thr_nxt;
        end
    end
    // valid in the cycle before proves run with no underflow, so the tx side is still in run
    chk_halt_on_unf: assert property (mac_tx_underflow && $past(mac_tx_valid) && err_r[0]
        |=> tx_halted && packet_event_interrupt == $past(pkt_event_int_en)) else $error("no halt after underflow");
    chk_drop_keeps_run: assert property (mac_tx_underflow && $past(mac_tx_valid) && !err_r[0]
        |=> !tx_halted && !packet_event_interrupt) else $error("drop policy halted");
    chk_halt_quiet: assert property (tx_halted |-> !tx_ready && !tx_in_ready && !mac_tx_valid)
        else $error("tx active while halted");
    chk_irq_cause: assert property (packet_event_interrupt |-> tx_halted && $past(mac_tx_underflow))
        else $error("stray packet event interrupt");
    chk_fc_grant: assert property (fc_grant == fc_req) else $error("flow control grant wrong");
    chk_halt_exit: assert property (tx_halted && tx_restart |=> !tx_halted) else $error("restart ignored");
    chk_rx_hidden: assert property (rx_out_valid && rx_out_word.ovf |-> err_r[8])
        else $error("overflowed word shown without pass");
    chk_fail_seen: assert property (rx_fail |-> rx_event_seen) else $error("fail without event");
    chk_pass_seen: assert property (rx_event_passed |-> rx_event_seen && err_r[8])
        else $error("pass pulse wrong");
    chk_rd_data: assert property (reg_cs && !reg_we |=> reg_rdata == $past(rd_exp))
        else $error("read data wrong");
endmodule : mfc_ctrl_monitor

bind mfc_ctrl mfc_ctrl_monitor #(.DEPTH(DEPTH), .BYTES_PER_WORD(BYTES_PER_WORD)) mfc_ctrl_monitor_i (
    .ref_clk, .srst, .reg_cs, .reg_we, .reg_addr, .reg_wdata, .reg_rdata, .pkt_event_int_en,
    .packet_event_interrupt, .tx_in_ready, .tx_ready, .mac_tx_valid, .mac_tx_underflow, .tx_restart,
    .tx_halted, .fc_req, .fc_grant, .rx_out_valid, .rx_out_word, .rx_fail, .rx_event_seen, .rx_event_passed
);

/* File: tb/mfc_host_model.sv */
// packet bus host model: feeds the tx fifo and takes words from the rx fifo
`timescale 1ns/1ps
module mfc_host_model (
    input wire logic ref_clk,
    input wire logic tx_in_ready,
    input wire logic rx_hold,
    output logic tx_in_valid,
    output mfc_pkg::mfc_tx_word_s tx_in_word,
    output logic rx_out_ready
);
    import mfc_pkg::*;
    // host takes rx words at once unless the bench stalls it
    assign rx_out_ready = !rx_hold;
    initial begin
        tx_in_valid = 1'b0;
        tx_in_word = '0;
    end
    // word held until accepted; released lines show the inverse, never the old value
    task automatic send(input mfc_tx_word_s w);
        tx_in_valid = 1'b1;
        tx_in_word = w;
        while (tx_in_ready !== 1'b1) @(posedge ref_clk) #1;
        @(posedge ref_clk) #1;
        tx_in_valid = 1'b0;
        tx_in_word = ~w;
        @(posedge ref_clk) #1;
    endtask : send
endmodule : mfc_host_model

/* File: tb/mfc_ctrl_tb.sv */
// self-checking bench for the mac fifo control block
`timescale 1ns/1ps
module mfc_ctrl_tb;
    import mfc_pkg::*;
    logic ref_clk, srst, reg_cs, reg_we, pkt_event_int_en, tx_in_valid, tx_in_ready, tx_ready, rd_p;
    logic mac_tx_valid, mac_tx_ready, mac_tx_underflow, tx_restart, tx_halted, fc_req, fc_grant;
    logic mac_rx_valid, mac_rx_ready, rx_ready, rx_out_valid, rx_out_ready, rx_fail, rx_hold;
    logic rx_event_seen, rx_event_passed, packet_event_interrupt;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    mfc_tx_word_s tx_in_word, mac_tx_word;
    mfc_rx_word_s mac_rx_word, rx_out_word;
    logic [65:0] exp_rd[$], exp_tx[$], exp_rx[$];
    int mismatches, checks_done, cyc, n_fail, n_seen, n_pass, n_irq, irq0;

    mfc_ctrl #(.DEPTH(8), .BYTES_PER_WORD(8)) mfc_ctrl_i (
        .ref_clk, .srst, .reg_cs, .reg_we, .reg_addr, .reg_wdata, .reg_rdata, .pkt_event_int_en,
        .packet_event_interrupt, .tx_in_valid, .tx_in_ready, .tx_in_word, .tx_ready, .mac_tx_valid,
        .mac_tx_ready, .mac_tx_word, .mac_tx_underflow, .tx_restart, .tx_halted, .fc_req, .fc_grant,
        .mac_rx_valid, .mac_rx_ready, .mac_rx_word, .rx_ready, .rx_out_valid, .rx_out_ready, .rx_out_word,
        .rx_fail, .rx_event_seen, .rx_event_passed
    );
    mfc_host_model mfc_host_model_i (.ref_clk, .tx_in_ready, .rx_hold, .tx_in_valid, .tx_in_word, .rx_out_ready);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic step(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_cs = 1'b1;
        reg_we = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step();
        {reg_cs, reg_we} = 2'b00;
        step();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_rd.push_back(66'(e));
        reg_cs = 1'b1;
        reg_addr = a;
        step();
        reg_cs = 1'b0;
        step();
    endtask : rd
    task automatic txw(input logic eop, input bit keep);
        mfc_tx_word_s w;
        w = {eop, $urandom, $urandom};
        if (keep) exp_tx.push_back(66'(w));
        mfc_host_model_i.send(w);
    endtask : txw
    // the mac side raises valid with a fresh word; rx_off releases the lines
    task automatic rxw(input logic [1:0] f, input bit keep);
        mfc_rx_word_s w;
        w = {f, $urandom, $urandom};
        if (keep) exp_rx.push_back(66'(w));
        mac_rx_valid = 1'b1;
        mac_rx_word = w;
        step();
    endtask : rxw
    task automatic rx_off();
        mac_rx_valid = 1'b0;
        mac_rx_word = ~mac_rx_word;
    endtask : rx_off

    // watcher: compares each result against the oldest note, counts pulses, cuts a hang
    always @(posedge ref_clk) begin
        if (rd_p) chk("reg_rdata", reg_rdata, exp_rd.pop_front());
        if (mac_tx_valid && mac_tx_ready) chk("mac_tx_word", mac_tx_word, exp_tx.pop_front());
        if (rx_out_valid && rx_out_ready) chk("rx_out_word", rx_out_word, exp_rx.pop_front());
        rd_p <= reg_cs && !reg_we && !srst;
        if (rx_fail) n_fail++;
        if (rx_event_seen) n_seen++;
        if (rx_event_passed) n_pass++;
        if (packet_event_interrupt) n_irq++;
        if (++cyc == 5000) begin
            mismatches++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {srst, reg_cs, reg_we, pkt_event_int_en, mac_tx_ready, mac_tx_underflow} = 6'h20;
        {tx_restart, fc_req, mac_rx_valid, rx_hold} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        mac_rx_word = '0;
        void'($urandom(32'h4a20_85c3));
        step(12);
        srst = 1'b0;
        // reset values, masking, unmapped space
        rd(8'h20, 16'h0000);
        rd(8'h22, 16'h0303);
        rd(8'h24, 16'h0000);
        wr(8'h24, 16'hffff);
        wr(8'h20, 16'hffff);
        wr(8'h22, 16'hffff);
        rd(8'h20, 16'h0101);
        rd(8'h22, 16'h3f7f);
        rd(8'h26, 16'h0000);
        // fill both fifos word by word, sweeping both thresholds at every level
        rx_hold = 1'b1;
        for (int n = 0; n <= 8; n++) begin
            for (int t = 0; t < 4; t++) begin
                wr(8'h22, 16'(t * 257));
                chk("tx_ready", tx_ready, (8 - n) * 8 >= 16 * (t + 1));
                chk("rx_ready", rx_ready, n * 8 >= 16 * (t + 1));
            end
            chk("tx_in_ready", tx_in_ready, n < 8);
            chk("mac_rx_ready", mac_rx_ready, n < 8);
            if (n < 8) begin
                rxw(2'b01, 1'b1);
                rx_off();
                txw(1'b1, 1'b1);
            end
        end
        mac_tx_ready = 1'b1;
        rx_hold = 1'b0;
        step(12);
        mac_tx_ready = 1'b0;
        chk("tx left", exp_tx.size(), 0);
        chk("rx left", exp_rx.size(), 0);
        // drop policy: underflow after the first word of a packet
        wr(8'h20, 16'h0000);
        txw(1'b0, 1'b1);
        txw(1'b1, 1'b0);
        txw(1'b1, 1'b1);
        mac_tx_ready = 1'b1;
        step();
        mac_tx_ready = 1'b0;
        mac_tx_underflow = 1'b1;
        step();
        mac_tx_underflow = 1'b0;
        step(4);
        chk("tx_halted", tx_halted, 1'b0);
        mac_tx_ready = 1'b1;
        step(4);
        mac_tx_ready = 1'b0;
        chk("tx left", exp_tx.size(), 0);
        // stop policy, with the interrupt enabled and then masked
        wr(8'h20, 16'h0001);
        for (int en = 1; en >= 0; en--) begin
            pkt_event_int_en = 1'(en);
            repeat (3) txw(1'b0, 1'b0);
            irq0 = n_irq;
            mac_tx_underflow = 1'b1;
            fc_req = 1'b1;
            step();
            mac_tx_underflow = 1'b0;
            chk("tx_halted", tx_halted, 1'b1);
            chk("tx_ready", tx_ready, 1'b0);
            chk("fc_grant", fc_grant, 1'b1);
            step(2);
            chk("irq count", n_irq - irq0, en);
            tx_restart = 1'b1;
            step();
            tx_restart = 1'b0;
            fc_req = 1'b0;
            chk("tx_halted", tx_halted, 1'b0);
            chk("mac_tx_valid", mac_tx_valid, 1'b0);
        end
        // overflowed rx packet, first discarded after it started, then passed
        wr(8'h20, 16'h0000);
        rxw(2'b00, 1'b1);
        rx_off();
        step(2);
        rxw(2'b10, 1'b0);
        rxw(2'b11, 1'b0);
        rx_off();
        step(4);
        chk("rx_fail count", n_fail, 1);
        chk("seen count", n_seen, 1);
        chk("passed count", n_pass, 0);
        wr(8'h20, 16'h0100);
        rxw(2'b10, 1'b1);
        rxw(2'b11, 1'b1);
        rx_off();
        step(4);
        chk("seen count", n_seen, 2);
        chk("passed count", n_pass, 1);
        chk("rx left", exp_rx.size(), 0);
        summarize();
    end
endmodule : mfc_ctrl_tb
